//--- src/idwr_pkg.sv
// Package for the interleaved DRAM write and refresh engine.
// Assumes a single system clock; all half-clock figures are counted in half-cycles
// of the strobe timer (strobes change on whole clocks, half clocks round up).
`default_nettype none
package idwr_pkg;

  // ==========================================================================
  // Buffer styles selected per channel pair
  // ==========================================================================
  typedef enum logic [1:0]
  {
    IDWR_BUF_NONE,       // Non-interleaved pair
    IDWR_BUF_XCVR,       // Plain transceiver
    IDWR_BUF_LATMUX,     // Latched multiplexer
    IDWR_BUF_REGXCVR     // Registered transceiver
  } idwr_buf_e;

  // ==========================================================================
  // Timing figures
  // ==========================================================================
  localparam int unsigned IDWR_CLK_PERIOD_PS   = 8000;  // 125 MHz
  localparam int unsigned IDWR_CAS_TO_RAS_CLK  = 1;     // Column strobe to even row strobe gap
  localparam int unsigned IDWR_RAS_EXTRA_HALF  = 1;     // Row strobe width is width + 0.5 clk
  localparam int unsigned IDWR_CAS_OFF_HALF    = 3;     // Column off 1.5 clk after odd row on
  localparam int unsigned IDWR_STAGGER_CLK     = 1;     // Odd row strobe lag behind even
  // Whole clocks covering the half-clock figures, rounded up
  localparam int unsigned IDWR_CAS_OFF_CLK     = (IDWR_CAS_OFF_HALF + 1) / 2;
  localparam int unsigned IDWR_RAS_EXTRA_CLK   = (IDWR_RAS_EXTRA_HALF + 1) / 2;
  localparam int unsigned IDWR_WIDTH_BITS      = 4;     // Column strobe width field
  localparam logic [3:0]  IDWR_WIDTH_RESET     = 4'h2;  // Default column strobe width

endpackage : idwr_pkg
`default_nettype wire

//--- src/idwr_refresh_seq.sv
// Staggered column-before-row refresh sequencer.
// Assumes start is a one-cycle pulse given only while idle.
`default_nettype none
module idwr_refresh_seq
#(
  parameter int unsigned WIDTH_BITS = idwr_pkg::IDWR_WIDTH_BITS
)
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Control
  input  wire logic                  start,
  input  wire logic [WIDTH_BITS-1:0] columnStrobeWidth,
  output logic                       busy,
  // Strobes, active high inside the block
  output logic                       casAll,
  output logic                       rasEven,
  output logic                       rasOdd
);

  // ==========================================================================
  // Event times relative to the first column strobe cycle
  // ==========================================================================
  localparam int unsigned CW = WIDTH_BITS + 2;
  logic [CW-1:0] tick;        // Cycles since start
  logic [CW-1:0] width;       // Column strobe width, at least one
  logic [CW-1:0] evenOn;      // Even row strobe rise
  logic [CW-1:0] oddOn;       // Odd row strobe rise
  logic [CW-1:0] rasLen;      // Row strobe length
  logic [CW-1:0] casOff;      // Column strobe fall

  always_comb
  begin
    width  = (columnStrobeWidth == '0) ? CW'(1) : CW'(columnStrobeWidth);
    evenOn = width + CW'(idwr_pkg::IDWR_CAS_TO_RAS_CLK);
    oddOn  = evenOn + CW'(idwr_pkg::IDWR_STAGGER_CLK);
    rasLen = width + CW'(idwr_pkg::IDWR_RAS_EXTRA_CLK);
    casOff = oddOn + CW'(idwr_pkg::IDWR_CAS_OFF_CLK);
  end

  // Cycle counter; sequence ends when the last row strobe drops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      tick <= '0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      tick <= '0;
    end
    else if (busy)
    begin
      if (tick == oddOn + rasLen - CW'(1))
        busy <= 1'b0;
      tick <= tick + CW'(1);
    end
  end

  // Strobes decoded from the counter, registered next cycle-aligned
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      casAll  <= 1'b0;
      rasEven <= 1'b0;
      rasOdd  <= 1'b0;
    end
    else
    begin
      casAll  <= (start && !busy) || (busy && (tick + CW'(1) < casOff));
      rasEven <= busy && (tick + CW'(1) >= evenOn) && (tick + CW'(1) < evenOn + rasLen);
      rasOdd  <= busy && (tick + CW'(1) >= oddOn) && (tick + CW'(1) < oddOn + rasLen);
    end
  end

endmodule : idwr_refresh_seq
`default_nettype wire

//--- src/idwr_engine.sv
// Interleaved DRAM write path and refresh arbitration engine.
// Assumes requests are held until accepted; buffer style per pair is a static input.
`default_nettype none
module idwr_engine
#(
  parameter int unsigned WIDTH_BITS = idwr_pkg::IDWR_WIDTH_BITS,
  parameter int unsigned BURST_MAX  = 4
)
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Configuration
  input  wire logic [1:0]            pairStyle0,
  input  wire logic [1:0]            pairStyle1,
  input  wire logic [WIDTH_BITS-1:0] column_strobe_width,
  // Write request from core or DMA
  input  wire logic                  writeReq,
  input  wire logic                  writeFromDma,
  input  wire logic [1:0]            writeBank,
  input  wire logic [2:0]            writeWords,
  output logic                       writeAck,
  output logic                       writeDone,
  // Refresh request and bus activity
  input  wire logic                  refreshReq,
  input  wire logic                  loadStoreActive,
  input  wire logic                  chipSelectActive,
  output logic                       refreshActive,
  // DRAM strobes, active low
  output logic [3:0]                 bank_row_strobe_n,
  output logic [3:0]                 bank_column_strobe_n,
  // Buffer controls, active low
  output logic                       even_path_read_enable_n,
  output logic                       odd_path_read_enable_n,
  output logic                       even_path_write_enable_n,
  output logic                       odd_path_write_enable_n,
  // Debug
  output logic                       unselected_access_indicator
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (BURST_MAX < 1 || BURST_MAX > 7)
    $error("BURST_MAX must lie in 1..7");
  if (WIDTH_BITS < 1 || WIDTH_BITS > 8)
    $error("WIDTH_BITS must lie in 1..8");

  // ==========================================================================
  // Write sequencer states
  // ==========================================================================
  typedef enum logic [2:0]
  {
    IDLE,
    ROW,       // Row strobe, write enable set up early
    COL,       // Column strobe for this word
    HOLD,      // Release and step to the next word
    REFRESH    // Refresh owns the DRAM strobes
  } idwr_state_e;

  idwr_state_e                 state;
  logic [1:0]                  bank;          // Current bank index
  logic [2:0]                  wordsLeft;     // Words still to write
  logic [WIDTH_BITS:0]         colCount;      // Column strobe cycles left
  logic                        multiWord;     // Transfer has more than one word
  logic                        secondCas;     // Second column pulse in progress
  logic                        refreshPending;// Latched refresh request
  logic                        refStart;      // One-cycle start to sequencer
  logic                        refBusy;       // Sequencer running
  logic                        refCas;        // Sequencer column strobe
  logic                        refRasEven;    // Sequencer even rows
  logic                        refRasOdd;     // Sequencer odd rows
  logic [1:0]                  style;         // Style of the addressed pair
  logic                        accept;        // Write accepted this cycle
  logic [2:0]                  reqWords;      // Legal word count of request
  logic [WIDTH_BITS:0]         widthClk;      // Column width, at least one

  // Style of the pair owning the current bank
  always_comb
  begin
    style = bank[1] ? pairStyle1 : pairStyle0;
  end

  // Core may only ever write one word; DMA bounded by burst limit
  always_comb
  begin
    if (!writeFromDma)
      reqWords = 3'h1;
    else if (writeWords == 3'h0)
      reqWords = 3'h1;
    else if (writeWords > 3'(BURST_MAX))
      reqWords = 3'(BURST_MAX);
    else
      reqWords = writeWords;
    widthClk = (column_strobe_width == '0) ? (WIDTH_BITS+1)'(1) : (WIDTH_BITS+1)'(column_strobe_width);
  end

  // Writes taken only when idle and no refresh waits
  always_comb
  begin
    accept = (state == IDLE) && writeReq && !refreshPending && !refreshReq;
  end

  // ==========================================================================
  // Refresh request latch and launch
  // ==========================================================================
  // Request held until the DRAM is free; the set beats the clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      refreshPending <= 1'b0;
    else if (refreshReq)
      refreshPending <= 1'b1;
    else if (refStart)
      refreshPending <= 1'b0;
  end

  // Launch pulse, only from idle so a write in flight finishes first
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      refStart <= 1'b0;
    else
      refStart <= (state == IDLE) && (refreshPending || refreshReq) && !refStart && !refBusy;
  end

  idwr_refresh_seq
  #(
    .WIDTH_BITS (WIDTH_BITS)
  )
  u_refresh
  (
    .clk               (clk),
    .rst               (rst),
    .start             (refStart),
    .columnStrobeWidth (column_strobe_width),
    .busy              (refBusy),
    .casAll            (refCas),
    .rasEven           (refRasEven),
    .rasOdd            (refRasOdd)
  );

  // ==========================================================================
  // Write sequencer
  // ==========================================================================
  // One word per pass; each word gets its own row and column strobes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state     <= IDLE;
      bank      <= 2'h0;
      wordsLeft <= 3'h0;
      colCount  <= '0;
      multiWord <= 1'b0;
      secondCas <= 1'b0;
    end
    else
    begin
      case (state)
        IDLE:
        begin
          if (refStart)
            state <= REFRESH;
          else if (accept)
          begin
            state     <= ROW;
            bank      <= writeBank;
            wordsLeft <= reqWords;
            multiWord <= (reqWords != 3'h1);
            secondCas <= 1'b0;
          end
        end
        ROW:
        begin
          state    <= COL;
          colCount <= widthClk;
        end
        COL:
        begin
          if (colCount == (WIDTH_BITS+1)'(1))
            state <= HOLD;
          colCount <= colCount - (WIDTH_BITS+1)'(1);
        end
        HOLD:
        begin
          // Multi-word transfers pulse the column strobe once more on the last word
          if (multiWord && !secondCas && wordsLeft == 3'h1)
          begin
            state     <= COL;
            secondCas <= 1'b1;
            colCount  <= widthClk;
          end
          else if (wordsLeft > 3'h1)
          begin
            state     <= ROW;
            wordsLeft <= wordsLeft - 3'h1;
            bank      <= {bank[1], ~bank[0]};
          end
          else
          begin
            state     <= IDLE;
            wordsLeft <= 3'h0;
          end
        end
        REFRESH:
        begin
          // Wait for the sequencer; busy rises a cycle after the start pulse
          if (!refBusy && !refStart)
            state <= IDLE;
        end
        default:
          state <= IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Handshake outputs
  // ==========================================================================
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      writeAck      <= 1'b0;
      writeDone     <= 1'b0;
      refreshActive <= 1'b0;
    end
    else
    begin
      writeAck      <= accept;
      writeDone     <= (state == HOLD) && (wordsLeft <= 3'h1) &&
                       !(multiWord && !secondCas && wordsLeft == 3'h1);
      refreshActive <= refBusy || refStart;
    end
  end

  // ==========================================================================
  // DRAM strobes
  // ==========================================================================
  // Refresh drives every bank; writes drive only the current bank
  logic writeRow;   // Row asserted for the current word
  logic writeCol;   // Column asserted for the current word
  always_comb
  begin
    writeRow = (state == ROW) || (state == COL) || (state == HOLD);
    writeCol = (state == COL);
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_bank
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          bank_row_strobe_n[gi]    <= 1'b1;
          bank_column_strobe_n[gi] <= 1'b1;
        end
        else if (refBusy)
        begin
          bank_row_strobe_n[gi]    <= (gi % 2 == 0) ? !refRasEven : !refRasOdd;
          bank_column_strobe_n[gi] <= !refCas;
        end
        else
        begin
          bank_row_strobe_n[gi]    <= !(writeRow && bank == 2'(gi));
          bank_column_strobe_n[gi] <= !(writeCol && bank == 2'(gi));
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Buffer controls per style
  // ==========================================================================
  // Write enable goes active at the row step, ahead of the column strobe
  logic oddBank;    // Current word in the odd path
  logic wrPhase;    // Write data path active
  always_comb
  begin
    oddBank = bank[0];
    wrPhase = writeRow && !refBusy && (state != REFRESH);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      even_path_read_enable_n  <= 1'b1;
      odd_path_read_enable_n   <= 1'b1;
      even_path_write_enable_n <= 1'b1;
      odd_path_write_enable_n  <= 1'b1;
    end
    else if (!wrPhase)
    begin
      // Refresh and idle keep both write enables off
      even_path_read_enable_n  <= 1'b1;
      odd_path_read_enable_n   <= 1'b1;
      even_path_write_enable_n <= 1'b1;
      odd_path_write_enable_n  <= 1'b1;
    end
    else
    begin
      case (idwr_pkg::idwr_buf_e'(style))
        idwr_pkg::IDWR_BUF_XCVR:
        begin
          // Read enables gate the transceiver, write enables set direction
          even_path_read_enable_n  <= oddBank;
          odd_path_read_enable_n   <= !oddBank;
          even_path_write_enable_n <= oddBank;
          odd_path_write_enable_n  <= !oddBank;
        end
        idwr_pkg::IDWR_BUF_LATMUX:
        begin
          // Even read enable is the odd-datum latch; odd read enable the mux gate,
          // both idle on writes, which steer through the write path enables
          even_path_read_enable_n  <= 1'b1;
          odd_path_read_enable_n   <= 1'b1;
          even_path_write_enable_n <= oddBank;
          odd_path_write_enable_n  <= !oddBank;
        end
        idwr_pkg::IDWR_BUF_REGXCVR:
        begin
          // Write enables map straight onto the odd and even register sides; read enables stay idle
          even_path_read_enable_n  <= 1'b1;
          odd_path_read_enable_n   <= 1'b1;
          even_path_write_enable_n <= oddBank;
          odd_path_write_enable_n  <= !oddBank;
        end
        default:
        begin
          // Non-interleaved pair: even path only
          even_path_read_enable_n  <= 1'b1;
          odd_path_read_enable_n   <= 1'b1;
          even_path_write_enable_n <= 1'b0;
          odd_path_write_enable_n  <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Debug indicator
  // ==========================================================================
  // Flags a load or store with neither chip select nor any row strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      unselected_access_indicator <= 1'b0;
    else
      unselected_access_indicator <= loadStoreActive && !chipSelectActive &&
                                     (&bank_row_strobe_n);
  end

endmodule : idwr_engine
`default_nettype wire

//--- testbench/idwr_engine_props.sv
// Checker for the DRAM write and refresh engine.
// Assumes it is bound to idwr_engine and sees its ports only.
`default_nettype none
module idwr_engine_props
#(
  parameter int unsigned WIDTH_BITS = 4,
  parameter int unsigned BURST_MAX  = 4
)
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Handshake and bus activity
  input wire logic       writeAck,
  input wire logic       loadStoreActive,
  input wire logic       chipSelectActive,
  input wire logic       refreshActive,
  // DRAM side, active low
  input wire logic [3:0] bank_row_strobe_n,
  input wire logic [3:0] bank_column_strobe_n,
  input wire logic       even_path_write_enable_n,
  input wire logic       odd_path_write_enable_n,
  // Debug
  input wire logic       unselected_access_indicator
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Properties, all on the one system clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_we_quiet_refresh: assert property (refreshActive |-> even_path_write_enable_n && odd_path_write_enable_n)
    else $error("write enable active during refresh");
  a_refresh_blocks_ack: assert property (refreshActive |-> !writeAck)
    else $error("write accepted during refresh");
  a_ack_row_follow: assert property (writeAck |=> bank_row_strobe_n != 4'h0_f)
    else $error("no row strobe after accept");
  a_ack_single: assert property (writeAck |=> !writeAck)
    else $error("accept pulse too long");
  // Early write: a path write enable is already low when a column strobe falls
  a_early_write: assert property ((!refreshActive && $fell(&bank_column_strobe_n))
    |-> !$past(even_path_write_enable_n) || !$past(odd_path_write_enable_n))
    else $error("column strobe before write enable");
  a_cas_before_ras: assert property ((refreshActive && $fell(bank_row_strobe_n[0]))
    |-> bank_column_strobe_n == 4'h0)
    else $error("even row strobe without all columns low");
  a_odd_stagger: assert property ((refreshActive && $fell(bank_row_strobe_n[0]))
    |=> $fell(bank_row_strobe_n[1]))
    else $error("odd row strobe not one clock after even");
  // Half a clock rounds up, so columns rise two clocks after odd rows fall
  a_cas_release: assert property ((refreshActive && $fell(bank_row_strobe_n[1]))
    |-> ##1 bank_column_strobe_n == 4'h0 ##1 bank_column_strobe_n == 4'h0_f)
    else $error("columns not released in time");
  a_debug_flag: assert property (1'b1 |=> unselected_access_indicator == ($past(loadStoreActive)
    && !$past(chipSelectActive) && $past(bank_row_strobe_n) == 4'h0_f))
    else $error("debug flag wrong");
endmodule : idwr_engine_props
`default_nettype wire

//--- testbench/idwr_dram_model.sv
// DRAM banks with data path buffers, seen from their pins.
// Assumes active-low strobes; reports each write access as it closes.
`default_nettype none
module idwr_dram_model
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Strobes and buffer enables, active low
  input wire logic [3:0]  rowN,
  input wire logic [3:0]  colN,
  input wire logic        evenRdN,
  input wire logic        oddRdN,
  input wire logic        evenWeN,
  input wire logic        oddWeN,
  // Report: bank, read enable seen, write enable seen
  output logic            word,
  output logic [3:0]      wordInfo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] prevRow;  // Row strobes one clock ago
  logic [3:0] inWrite;  // Row opened with column high, so not a refresh
  logic [3:0] rdLow;    // Path read enable seen low during access
  logic [3:0] weLow;    // Path write enable seen low during access
  // ==========================================================
  // Access tracking; column-before-row openings are refreshes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {prevRow, inWrite, rdLow, weLow, word, wordInfo} <= {4'h0_f, 12'h0_00, 5'h00};
    end
    else
    begin
      prevRow <= rowN;
      word    <= 1'b0;
      for (int b = 0; b < 4; b++)
      begin
        if (prevRow[b] && !rowN[b])
        begin
          inWrite[b] <= colN[b];
          rdLow[b]   <= 1'b0;
          weLow[b]   <= 1'b0;
        end
        else if (!rowN[b])
        begin
          rdLow[b] <= rdLow[b] | !(b[0] ? oddRdN : evenRdN);
          weLow[b] <= weLow[b] | !(b[0] ? oddWeN : evenWeN);
        end
        else if (!prevRow[b] && inWrite[b])
        begin
          word       <= 1'b1;
          wordInfo   <= {b[1:0], rdLow[b], weLow[b]};
          inWrite[b] <= 1'b0;
        end
      end
    end
  end
endmodule : idwr_dram_model
`default_nettype wire

//--- testbench/idwr_engine_tb.sv
// Self-checking bench for the DRAM write and refresh engine.
// Assumes the DRAM model and checker files are compiled first.
`default_nettype none
module idwr_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, writeReq, writeFromDma, refreshReq, writeAck, writeDone;
  logic       loadStoreActive, chipSelectActive, refreshActive, unsel, word, refSeen;
  logic [1:0] pairStyle0, pairStyle1, writeBank;
  logic [2:0] writeWords;
  logic [3:0] width, rowN, colN, wordInfo;
  logic       evRdN, odRdN, evWeN, odWeN;
  logic [3:0] expQ[$];  // Expected access reports, oldest first
  int         fails, n_tests;
  integer     seed = 32'hf70a1185;
  // ==========================================================
  // Clock and parts
  initial begin clk = 1'b0; forever #4 clk = ~clk; end
  idwr_engine dut (.clk(clk), .rst(rst), .pairStyle0(pairStyle0), .pairStyle1(pairStyle1),
    .column_strobe_width(width), .writeReq(writeReq), .writeFromDma(writeFromDma),
    .writeBank(writeBank), .writeWords(writeWords), .writeAck(writeAck), .writeDone(writeDone),
    .refreshReq(refreshReq), .loadStoreActive(loadStoreActive), .chipSelectActive(chipSelectActive),
    .refreshActive(refreshActive), .bank_row_strobe_n(rowN), .bank_column_strobe_n(colN),
    .even_path_read_enable_n(evRdN), .odd_path_read_enable_n(odRdN), .even_path_write_enable_n(evWeN),
    .odd_path_write_enable_n(odWeN), .unselected_access_indicator(unsel));
  idwr_dram_model mem (.clk(clk), .rst(rst), .rowN(rowN), .colN(colN), .evenRdN(evRdN), .oddRdN(odRdN),
    .evenWeN(evWeN), .oddWeN(odWeN), .word(word), .wordInfo(wordInfo));
  // ==========================================================
  // Comparison, verdict and watchdog
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      fails++;
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin repeat (20000) @(posedge clk); fails++; stop_test(); end
  // Watcher: each closed access is matched to the oldest note
  always @(posedge clk)
  begin
    if (word) check("access", expQ.size() > 0 ? expQ.pop_front() : 4'hx, wordInfo);
  end
  // ==========================================================
  // One write; a pending refresh pulse is dropped after one clock
  task automatic do_write(input logic dma, input logic [1:0] bank, input logic [2:0] words);
    int n;
    int cols;
    logic [1:0] b;
    logic [3:0] prevCol;
    n = !dma ? 1 : (words == 0) ? 1 : (words > 4) ? 4 : int'(words);
    for (int i = 0; i < n; i++)
    begin
      b = {bank[1], bank[0] ^ i[0]};
      expQ.push_back({b, (b[1] ? pairStyle1 : pairStyle0) == 2'd1, 1'b1});
    end
    {writeReq, writeFromDma, writeBank, writeWords} = {1'b1, dma, bank, words};
    // Refresh seen only while the write still waits counts as refresh first
    for (int k = 0; k < 300 && writeAck !== 1'b1; k++)
    begin
      @(negedge clk);
      refreshReq = 1'b0;
      if (refreshActive === 1'b1)
        refSeen = 1'b1;
    end
    check("write ack", 4'h1, {3'h0, writeAck});
    writeReq = 1'b0;
    cols = 0;
    prevCol = 4'hf;
    // Count column strobe falls up to the done pulse
    for (int k = 0; k < 300 && writeDone !== 1'b1; k++)
    begin
      @(negedge clk);
      if (prevCol === 4'hf && colN !== 4'hf)
        cols++;
      prevCol = colN;
    end
    check("write done", 4'h1, {3'h0, writeDone});
    check("column pulses", 4'(n + int'(n > 1)), 4'(cols));
    @(negedge clk);
    $display("write test done, %0d words", n);
  endtask : do_write
  // ==========================================================
  // Main sequence
  initial
  begin
    {rst, writeReq, writeFromDma, refreshReq, loadStoreActive, chipSelectActive, refSeen} = 7'h40;
    {pairStyle0, pairStyle1, writeBank, writeWords, width} = {2'd1, 2'd2, 2'd0, 3'd0, 4'h2};
    fails = 0;
    n_tests = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int s = 1; s < 4; s++)
    begin
      pairStyle0 = 2'(s);
      pairStyle1 = 2'(s % 3 + 1);
      do_write(1'b0, 2'($random(seed)), 3'd5);
      do_write(1'b1, 2'($random(seed)), 3'($random(seed)));
      do_write(1'b1, 2'd3, 3'd7);
    end
    // Refresh beside a non-DRAM load, with a DRAM write waiting
    for (int w = 1; w < 5; w++)
    begin
      width = 4'(w);
      {loadStoreActive, chipSelectActive, refSeen, refreshReq} = 4'b1001;
      do_write(1'b1, 2'($random(seed)), 3'd2);
      check("refresh first", 4'h1, {3'h0, refSeen});
      loadStoreActive = 1'b0;
    end
    repeat (20) @(negedge clk);
    check("notes left", 4'h0, 4'(expQ.size()));
    stop_test();
  end
endmodule : idwr_engine_tb
bind idwr_engine idwr_engine_props #(.WIDTH_BITS(WIDTH_BITS), .BURST_MAX(BURST_MAX)) props (.clk(clk),
  .rst(rst), .writeAck(writeAck), .loadStoreActive(loadStoreActive), .chipSelectActive(chipSelectActive),
  .refreshActive(refreshActive), .bank_row_strobe_n(bank_row_strobe_n),
  .bank_column_strobe_n(bank_column_strobe_n), .even_path_write_enable_n(even_path_write_enable_n),
  .odd_path_write_enable_n(odd_path_write_enable_n), .unselected_access_indicator(unselected_access_indicator));
`default_nettype wire
